/* File: inc/servo_supervisor_defines.vh */
// register indices, field positions, reset values and timing constants
// assumes byte address = 4 * index on a 32-bit apb bus
`ifndef SERVO_SUPERVISOR_DEFINES_VH
`define SERVO_SUPERVISOR_DEFINES_VH
`define IDX_CMD 8'h1E
`define IDX_PRESET 8'h27
`define IDX_FWD 8'h48
`define IDX_SLEN 8'h53
`define IDX_PLIM 8'h54
`define IDX_RLIM 8'h55
`define IDX_OFFDLY 8'h8F
`define IDX_COMTO 8'h94
`define IDX_STATE 8'hA0
`define IDX_IRQ_STAT 8'hA1
`define IDX_IRQ_MASK 8'hA2
`define IDX_POS_IN 8'hA3
`define IDX_MODE 8'hA4
`define IDX_GSEL 8'hA5
`define BIT_SERVO_ON 0
`define BIT_GAIN2 11
`define BIT_SENS_ARST 12
`define BIT_ORIGIN_EN 13
`define BIT_POS_PRESET 14
`define BIT_SENS_MRST 15
`define RST_PRESET 32'h00000000
`define RST_OFFDLY 16'h0000
`define RST_COMTO 16'h03E8
`define MAX_OFFDLY 16'h2710
`define MAX_COMTO 16'h2710
`define MS_TIME_NS 1000000
`define CLK_PERIOD_NS 10
`define MS_CYCLES (`MS_TIME_NS / `CLK_PERIOD_NS)
`define EV_SOFTLIM 0
`define EV_COMLOSS 1
`define EV_OFFDONE 2
`define EV_ORIGIN 3
`define MODE_POS 2'h0
`define MODE_SPD 2'h1
`endif

/* File: rtl/servo_command_supervisor.v */
// servo command supervisor: command word decode, off delay, direction,
// soft limits and communication-loss watchdog behind an apb slave
// assumes a 100 MHz clock and host-link activity pulses synchronous to it
//
// Contract
// - bit 11 selects second gain set
// - bit 12 clears absolute sensor alarms
// - bit 13 enables origin detection acceptance
// - bit 14 loads position from preset
// - bit 15 clears sensor alarms and turns
// - off delay is 0 to 10000 ms
// - servo stays energised for off delay
// - direction zero ccw, one cw forward
// - direction setting inverts reported position sign
// - soft limits signed, active only when enabled
// - limit passed forces zero speed, pos/speed modes
// - link silence for timeout turns servo off
// - timeout 1 to 10000 ms, zero disables
`include "servo_supervisor_defines.vh"
`default_nettype none
module servo_command_supervisor #(
    parameter MS_CYCLES = `MS_CYCLES
) (
    input wire REF_CLK,
    input wire RST_N,
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [11:0] PADDR,
    input wire [31:0] PWDATA,
    output wire [31:0] PRDATA,
    output wire PREADY,
    output wire PSLVERR,
    input wire USB_RX_VALID,
    input wire BUS_RX_VALID,
    input wire ORIGIN_SIGNAL,
    input wire [31:0] RAW_POSITION,
    output wire GAIN_SET2,
    output wire SENSOR_ALARM_CLEAR,
    output wire SENSOR_MULTITURN_CLEAR,
    output wire ORIGIN_DETECTED,
    output wire POSITION_LOAD,
    output wire [31:0] POSITION_LOAD_VALUE,
    output wire [31:0] REPORTED_POSITION,
    output wire DIRECTION_CW,
    output wire SERVO_ENERGISED,
    output wire ZERO_SPEED_FORCE,
    output wire IRQ
);
    localparam ST_OFF = 3'b001;
    localparam ST_ON = 3'b010;
    localparam ST_DELAY = 3'b100;

    reg [15:0] cmd_reg;
    reg [31:0] preset_reg;
    reg fwd_reg;
    reg slen_reg;
    reg [31:0] plim_reg;
    reg [31:0] rlim_reg;
    reg [15:0] offdly_reg;
    reg [15:0] comto_reg;
    reg [1:0] mode_reg;
    reg [2:0] gsel_reg;
    reg [3:0] irq_stat_reg;
    reg [3:0] irq_mask_reg;
    reg [2:0] state_reg;
    reg [15:0] cmd_prev_reg;
    reg [31:0] ms_cnt_reg;
    reg [15:0] dly_cnt_reg;
    reg [15:0] wd_cnt_reg;
    reg wd_cut_reg;
    reg sens_arst_reg;
    reg sens_mrst_reg;
    reg pos_load_reg;
    reg origin_reg;
    reg zero_spd_reg;
    reg [31:0] prdata_reg;
    reg [31:0] pos_rep_reg;
    reg [31:0] rd_mux;
    reg [3:0] events;

    wire wr_en = PSEL && PENABLE && PWRITE;
    // read data is captured in the setup cycle so it stands at the access edge
    wire rd_setup = PSEL && !PENABLE && !PWRITE;
    wire [9:0] idx = PADDR[11:2];
    wire ms_tick = (ms_cnt_reg == MS_CYCLES - 1);
    wire link_rx = USB_RX_VALID || BUS_RX_VALID;
    wire servo_req = cmd_reg[`BIT_SERVO_ON] && !wd_cut_reg;
    wire [15:0] cmd_rise = cmd_reg & ~cmd_prev_reg;
    wire mode_ok = (mode_reg == `MODE_POS) || (mode_reg == `MODE_SPD);
    wire [31:0] pos_signed = fwd_reg ? (~RAW_POSITION + 32'h00000001) : RAW_POSITION;
    wire beyond = ($signed(pos_signed) > $signed(plim_reg)) ||
                  ($signed(pos_signed) < $signed(rlim_reg));

    // true for every index that has a register behind it
    function is_mapped;
        input [9:0] index;
        begin
            case (index)
                `IDX_CMD: is_mapped = 1'b1;
                `IDX_PRESET: is_mapped = 1'b1;
                `IDX_FWD: is_mapped = 1'b1;
                `IDX_SLEN: is_mapped = 1'b1;
                `IDX_PLIM: is_mapped = 1'b1;
                `IDX_RLIM: is_mapped = 1'b1;
                `IDX_OFFDLY: is_mapped = 1'b1;
                `IDX_COMTO: is_mapped = 1'b1;
                `IDX_STATE: is_mapped = 1'b1;
                `IDX_IRQ_STAT: is_mapped = 1'b1;
                `IDX_IRQ_MASK: is_mapped = 1'b1;
                `IDX_POS_IN: is_mapped = 1'b1;
                `IDX_MODE: is_mapped = 1'b1;
                `IDX_GSEL: is_mapped = 1'b1;
                default: is_mapped = 1'b0;
            endcase
        end
    endfunction

    wire mapped = is_mapped(idx);

    // clamp a millisecond setting to its legal ceiling
    function [15:0] clamp_ms;
        input [31:0] value;
        input [15:0] ceiling;
        begin
            if (value[31:16] != 16'h0000 || value[15:0] > ceiling) begin
                clamp_ms = ceiling;
            end else begin
                clamp_ms = value[15:0];
            end
        end
    endfunction

    assign PREADY = 1'b1;
    assign PSLVERR = PSEL && PENABLE && !mapped;
    assign PRDATA = prdata_reg;
    assign GAIN_SET2 = cmd_reg[`BIT_GAIN2];
    assign SENSOR_ALARM_CLEAR = sens_arst_reg;
    assign SENSOR_MULTITURN_CLEAR = sens_mrst_reg;
    assign ORIGIN_DETECTED = origin_reg;
    assign POSITION_LOAD = pos_load_reg;
    assign POSITION_LOAD_VALUE = preset_reg;
    assign REPORTED_POSITION = pos_rep_reg;
    assign DIRECTION_CW = fwd_reg;
    assign SERVO_ENERGISED = (state_reg != ST_OFF);
    assign ZERO_SPEED_FORCE = zero_spd_reg;
    assign IRQ = |(irq_stat_reg & irq_mask_reg);

    always @* begin
        rd_mux = 32'h00000000;
        case (idx)
            `IDX_CMD: begin
                rd_mux = {16'h0000, cmd_reg};
            end
            `IDX_PRESET: begin
                rd_mux = preset_reg;
            end
            `IDX_FWD: begin
                rd_mux = {31'h00000000, fwd_reg};
            end
            `IDX_SLEN: begin
                rd_mux = {31'h00000000, slen_reg};
            end
            `IDX_PLIM: begin
                rd_mux = plim_reg;
            end
            `IDX_RLIM: begin
                rd_mux = rlim_reg;
            end
            `IDX_OFFDLY: begin
                rd_mux = {16'h0000, offdly_reg};
            end
            `IDX_COMTO: begin
                rd_mux = {16'h0000, comto_reg};
            end
            `IDX_STATE: begin
                rd_mux = {27'h0000000, zero_spd_reg, wd_cut_reg, state_reg};
            end
            `IDX_IRQ_STAT: begin
                rd_mux = {28'h0000000, irq_stat_reg};
            end
            `IDX_IRQ_MASK: begin
                rd_mux = {28'h0000000, irq_mask_reg};
            end
            `IDX_POS_IN: begin
                rd_mux = pos_rep_reg;
            end
            `IDX_MODE: begin
                rd_mux = {30'h00000000, mode_reg};
            end
            `IDX_GSEL: begin
                rd_mux = {29'h00000000, gsel_reg};
            end
            default: begin
                rd_mux = 32'h00000000;
            end
        endcase
    end

    // zero wait states: the word must already stand when the access edge comes
    always @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            prdata_reg <= 32'h00000000;
        end else if (rd_setup) begin
            prdata_reg <= rd_mux;
        end
    end

    always @* begin
        events = 4'h0;
        events[`EV_SOFTLIM] = slen_reg && mode_ok && beyond && !zero_spd_reg;
        events[`EV_COMLOSS] = (comto_reg != 16'h0000) && ms_tick && !link_rx &&
                              (wd_cnt_reg == comto_reg - 16'h0001) && !wd_cut_reg;
        events[`EV_OFFDONE] = (state_reg == ST_DELAY) && !servo_req &&
                              ((dly_cnt_reg >= offdly_reg));
        events[`EV_ORIGIN] = cmd_reg[`BIT_ORIGIN_EN] && ORIGIN_SIGNAL && !origin_reg;
    end

    always @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            cmd_reg <= 16'h0000;
            preset_reg <= `RST_PRESET;
            fwd_reg <= 1'b0;
            slen_reg <= 1'b0;
            plim_reg <= 32'h7FFFFFFF;
            rlim_reg <= 32'h80000000;
            offdly_reg <= `RST_OFFDLY;
            comto_reg <= `RST_COMTO;
            mode_reg <= `MODE_POS;
            gsel_reg <= 3'h0;
            irq_stat_reg <= 4'h0;
            irq_mask_reg <= 4'h0;
        end else begin
            if (wr_en) begin
                case (idx)
                    `IDX_CMD: begin
                        cmd_reg <= PWDATA[15:0];
                    end
                    `IDX_PRESET: begin
                        preset_reg <= PWDATA;
                    end
                    `IDX_FWD: begin
                        fwd_reg <= PWDATA[0];
                    end
                    `IDX_SLEN: begin
                        slen_reg <= PWDATA[0];
                    end
                    `IDX_PLIM: begin
                        plim_reg <= PWDATA;
                    end
                    `IDX_RLIM: begin
                        rlim_reg <= PWDATA;
                    end
                    `IDX_OFFDLY: begin
                        offdly_reg <= clamp_ms(PWDATA, `MAX_OFFDLY);
                    end
                    `IDX_COMTO: begin
                        comto_reg <= clamp_ms(PWDATA, `MAX_COMTO);
                    end
                    `IDX_IRQ_MASK: begin
                        irq_mask_reg <= PWDATA[3:0];
                    end
                    `IDX_MODE: begin
                        mode_reg <= PWDATA[1:0];
                    end
                    `IDX_GSEL: begin
                        gsel_reg <= PWDATA[2:0];
                    end
                    default: begin
                        cmd_reg <= cmd_reg;
                    end
                endcase
            end
            // set wins over write-one-to-clear
            if (wr_en && idx == `IDX_IRQ_STAT) begin
                irq_stat_reg <= (irq_stat_reg & ~PWDATA[3:0]) | events;
            end else begin
                irq_stat_reg <= irq_stat_reg | events;
            end
        end
    end

    always @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            cmd_prev_reg <= 16'h0000;
            sens_arst_reg <= 1'b0;
            sens_mrst_reg <= 1'b0;
            pos_load_reg <= 1'b0;
            origin_reg <= 1'b0;
            pos_rep_reg <= 32'h00000000;
            zero_spd_reg <= 1'b0;
        end else begin
            cmd_prev_reg <= cmd_reg;
            sens_arst_reg <= cmd_rise[`BIT_SENS_ARST];
            sens_mrst_reg <= cmd_rise[`BIT_SENS_MRST];
            pos_load_reg <= cmd_rise[`BIT_POS_PRESET];
            // latched until the homing enable drops
            if (!cmd_reg[`BIT_ORIGIN_EN]) begin
                origin_reg <= 1'b0;
            end else if (ORIGIN_SIGNAL) begin
                origin_reg <= 1'b1;
            end
            pos_rep_reg <= pos_signed;
            zero_spd_reg <= slen_reg && mode_ok && beyond;
        end
    end

    // shared millisecond base; watchdog and off delay are only ms-accurate
    always @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            ms_cnt_reg <= 32'h00000000;
        end else if (ms_tick) begin
            ms_cnt_reg <= 32'h00000000;
        end else begin
            ms_cnt_reg <= ms_cnt_reg + 32'h00000001;
        end
    end

    always @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            wd_cnt_reg <= 16'h0000;
            wd_cut_reg <= 1'b0;
        end else begin
            if (link_rx || comto_reg == 16'h0000) begin
                wd_cnt_reg <= 16'h0000;
            end else if (ms_tick && wd_cnt_reg != comto_reg) begin
                wd_cnt_reg <= wd_cnt_reg + 16'h0001;
            end
            // cut stays until software drops the servo-on bit
            if (!cmd_reg[`BIT_SERVO_ON]) begin
                wd_cut_reg <= 1'b0;
            end else if (events[`EV_COMLOSS]) begin
                wd_cut_reg <= 1'b1;
            end
        end
    end

    always @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            state_reg <= ST_OFF;
            dly_cnt_reg <= 16'h0000;
        end else begin
            case (state_reg)
                ST_OFF: begin
                    dly_cnt_reg <= 16'h0000;
                    if (servo_req) begin
                        state_reg <= ST_ON;
                    end
                end
                ST_ON: begin
                    dly_cnt_reg <= 16'h0000;
                    if (!servo_req) begin
                        state_reg <= ST_DELAY;
                    end
                end
                ST_DELAY: begin
                    if (servo_req) begin
                        state_reg <= ST_ON;
                    end else if (dly_cnt_reg >= offdly_reg) begin
                        state_reg <= ST_OFF;
                    end else if (ms_tick) begin
                        dly_cnt_reg <= dly_cnt_reg + 16'h0001;
                    end
                end
                default: state_reg <= ST_OFF;
            endcase
        end
    end
endmodule
`default_nettype wire

/* File: tb/servo_supervisor_checker.sv */
// checker: port-level rules of the servo command supervisor
// assumes one clock domain, bound to the top module
`include "servo_supervisor_defines.vh"
`default_nettype none
module servo_supervisor_checker (
    input wire logic REF_CLK,
    input wire logic RST_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire logic [31:0] RAW_POSITION,
    input wire logic GAIN_SET2,
    input wire logic SENSOR_ALARM_CLEAR,
    input wire logic SENSOR_MULTITURN_CLEAR,
    input wire logic POSITION_LOAD,
    input wire logic [31:0] REPORTED_POSITION,
    input wire logic DIRECTION_CW,
    input wire logic ZERO_SPEED_FORCE,
    input wire logic IRQ
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!RST_N);
    wire acc = PSEL && PENABLE && PWRITE;
    wire cmd_w = acc && PADDR == {2'h0, `IDX_CMD, 2'h0};
    wire fwd_w = acc && PADDR == {2'h0, `IDX_FWD, 2'h0};
    logic slen_q;
    // shadow of the limit enable, so the checker knows when limits are off
    always_ff @(posedge REF_CLK or negedge RST_N)
        if (!RST_N) slen_q <= 1'b0;
        else if (acc && PADDR == {2'h0, `IDX_SLEN, 2'h0}) slen_q <= PWDATA[0];
    gain_follow_a: assert property (cmd_w |=> GAIN_SET2 == $past(PWDATA[11]))
        else $error("gain select mismatch");
    alarm_pulse_a: assert property (SENSOR_ALARM_CLEAR |=> !SENSOR_ALARM_CLEAR)
        else $error("alarm clear too long");
    turns_pulse_a: assert property (SENSOR_MULTITURN_CLEAR |=> !SENSOR_MULTITURN_CLEAR)
        else $error("turn clear too long");
    load_pulse_a: assert property (POSITION_LOAD |=> !POSITION_LOAD)
        else $error("position load too long");
    dir_follow_a: assert property (fwd_w |=> DIRECTION_CW == $past(PWDATA[0]))
        else $error("direction mismatch");
    report_sign_a: assert property ($past(RST_N) |-> REPORTED_POSITION ==
        ($past(DIRECTION_CW) ? -$past(RAW_POSITION) : $past(RAW_POSITION)))
        else $error("reported sign wrong");
    limit_off_a: assert property (!slen_q && !$past(slen_q) |-> !ZERO_SPEED_FORCE)
        else $error("stop while limits off");
    ready_high_a: assert property (PREADY)
        else $error("ready low");
    err_phase_a: assert property (PSLVERR |-> PSEL && PENABLE)
        else $error("error outside access");
    cover property ($rose(POSITION_LOAD));
    cover property ($rose(ZERO_SPEED_FORCE));
    cover property ($rose(IRQ));
endmodule
bind servo_command_supervisor servo_supervisor_checker chk_u (.REF_CLK, .RST_N, .PSEL,
    .PENABLE, .PWRITE, .PADDR, .PWDATA, .PREADY, .PSLVERR, .RAW_POSITION, .GAIN_SET2,
    .SENSOR_ALARM_CLEAR, .SENSOR_MULTITURN_CLEAR, .POSITION_LOAD, .REPORTED_POSITION,
    .DIRECTION_CW, .ZERO_SPEED_FORCE, .IRQ);
`default_nettype wire

/* File: tb/host_link_model.sv */
// host link model: periodic message strobes on both host links
// assumes one clock; strobes only while talk is high
`default_nettype none
module host_link_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic talk,
    output logic usb_valid,
    output logic bus_valid
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] cnt;
    // one message per 8 cycles, inside any timeout of 2 ms or more
    always @(posedge clk or negedge rst_n)
        if (!rst_n) cnt <= 4'h0;
        else cnt <= talk ? cnt + 4'h1 : 4'h0;
    assign usb_valid = talk && cnt[2:0] == 3'h7 && !cnt[3];
    assign bus_valid = talk && cnt[2:0] == 3'h7 && cnt[3];
endmodule
`default_nettype wire

/* File: tb/servo_command_supervisor_test.sv */
// testbench: apb sequences against the servo command supervisor
// assumes 10-cycle millisecond tick and the host link model
`include "servo_supervisor_defines.vh"
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin num_errors++; \
    $display("BAD %0t got %h exp %h", $time, (a), (e)); end end
module servo_command_supervisor_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, talk = 0, origin = 0, err;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, raw = 0, rd_d;
    wire [31:0] prdata, ldv, rep;
    wire pready, pslverr, usb, bus, gain2, ac, mt, orgd, ld, cw, energ, zsf, irq;
    int num_errors = 0, checked = 0, n_ac = 0, n_mt = 0, n_ld = 0, t;
    servo_command_supervisor #(.MS_CYCLES(10)) dut_u (.REF_CLK(clk), .RST_N(rst_n),
        .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .USB_RX_VALID(usb),
        .BUS_RX_VALID(bus), .ORIGIN_SIGNAL(origin), .RAW_POSITION(raw), .GAIN_SET2(gain2),
        .SENSOR_ALARM_CLEAR(ac), .SENSOR_MULTITURN_CLEAR(mt), .ORIGIN_DETECTED(orgd),
        .POSITION_LOAD(ld), .POSITION_LOAD_VALUE(ldv), .REPORTED_POSITION(rep),
        .DIRECTION_CW(cw), .SERVO_ENERGISED(energ), .ZERO_SPEED_FORCE(zsf), .IRQ(irq));
    host_link_model host_u (.clk(clk), .rst_n(rst_n), .talk(talk), .usb_valid(usb),
        .bus_valid(bus));
    always #5 clk = ~clk;
    always @(posedge clk) begin
        n_ac <= n_ac + ac;
        n_mt <= n_mt + mt;
        n_ld <= n_ld + ld;
    end
    task tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task xfer(input logic w, input logic [7:0] i, input logic [31:0] d);
        @(posedge clk);
        psel <= 1;
        pwrite <= w;
        paddr <= {2'h0, i, 2'h0};
        pwdata <= d;
        @(posedge clk);
        penable <= 1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        err = pslverr;
        rd_d = prdata;
        psel <= 0;
        penable <= 0;
    endtask
    task wr(input logic [7:0] i, input logic [31:0] d);
        xfer(1, i, d);
    endtask
    task rd(input logic [7:0] i, input logic [31:0] e);
        xfer(0, i, 0);
        `CHK(rd_d, e)
    endtask
    // off-edge count of cycles until the servo drops, bounded
    task drop_time(input int lim);
        t = 0;
        while (energ === 1'b1 && t < lim) begin
            @(posedge clk);
            t++;
        end
    endtask
    task end_sim;
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        #400000;
        num_errors++;
        end_sim;
    end
    initial begin
        tick(2);
        rst_n <= 1;
        rd(`IDX_PRESET, `RST_PRESET);
        rd(`IDX_OFFDLY, `RST_OFFDLY);
        rd(`IDX_COMTO, `RST_COMTO);
        wr(`IDX_OFFDLY, 32'hFFFF);
        rd(`IDX_OFFDLY, `MAX_OFFDLY);
        wr(`IDX_COMTO, 32'h2711);
        rd(`IDX_COMTO, `MAX_COMTO);
        rd(8'h10, 32'h0);
        `CHK(err, 1'b1)
        $display("test regs done");
        talk <= 1;
        wr(`IDX_GSEL, 5);
        wr(`IDX_PRESET, 32'h80000001);
        wr(`IDX_CMD, 32'hD800);
        origin <= 1;
        tick(3);
        `CHK(orgd, 1'b0)
        `CHK(gain2, 1'b1)
        `CHK(ldv, 32'h80000001)
        wr(`IDX_CMD, 32'hF800);
        tick(3);
        `CHK(orgd, 1'b1)
        `CHK(n_ac, 1)
        `CHK(n_mt, 1)
        `CHK(n_ld, 1)
        wr(`IDX_CMD, 32'h0);
        tick(1);
        `CHK(gain2, 1'b0)
        origin <= 0;
        $display("test command done");
        raw <= 5;
        wr(`IDX_FWD, 1);
        tick(2);
        `CHK(cw, 1'b1)
        `CHK(rep, 32'hFFFFFFFB)
        wr(`IDX_FWD, 0);
        tick(2);
        `CHK(rep, 32'h5)
        $display("test direction done");
        wr(`IDX_PLIM, 100);
        wr(`IDX_RLIM, 32'hFFFFFF9C);
        wr(`IDX_MODE, `MODE_POS);
        wr(`IDX_IRQ_MASK, 1);
        raw <= 200;
        tick(2);
        `CHK(zsf, 1'b0)
        wr(`IDX_SLEN, 1);
        tick(2);
        `CHK(zsf, 1'b1)
        `CHK(irq, 1'b1)
        wr(`IDX_MODE, 2);
        tick(2);
        `CHK(zsf, 1'b0)
        wr(`IDX_MODE, `MODE_SPD);
        raw <= 32'hFFFFFF00;
        tick(2);
        `CHK(zsf, 1'b1)
        raw <= 50;
        wr(`IDX_IRQ_STAT, 32'hF);
        tick(1);
        `CHK(irq, 1'b0)
        wr(`IDX_IRQ_MASK, 0);
        raw <= 200;
        tick(2);
        `CHK(irq, 1'b0)
        wr(`IDX_SLEN, 0);
        rd(`IDX_IRQ_STAT, 1);
        wr(`IDX_IRQ_STAT, 1);
        rd(`IDX_IRQ_STAT, 0);
        $display("test limits done");
        wr(`IDX_OFFDLY, 3);
        wr(`IDX_CMD, 1);
        tick(5);
        wr(`IDX_CMD, 0);
        drop_time(100);
        `CHK(t >= 19 && t <= 32, 1'b1)
        wr(`IDX_OFFDLY, 0);
        wr(`IDX_COMTO, 2);
        wr(`IDX_CMD, 1);
        tick(100);
        `CHK(energ, 1'b1)
        talk <= 0;
        drop_time(200);
        `CHK(t >= 8 && t <= 35, 1'b1)
        wr(`IDX_CMD, 0);
        wr(`IDX_COMTO, 0);
        wr(`IDX_CMD, 1);
        tick(300);
        `CHK(energ, 1'b1)
        $display("test servo done");
        end_sim;
    end
endmodule
`default_nettype wire
